// ===== rtl/clock_conditioner_cfg.svh
/*
  Bit positions, widths and register offsets for the clock conditioner
  dynamic configuration block.
  Assumes inclusion by bare name from rtl/.
*/
`ifndef CLOCK_CONDITIONER_CFG_SVH
`define CLOCK_CONDITIONER_CFG_SVH

`define CFG_WIDTH 81
`define CFG_WORDS 3
`define CFG_CNT_W 7
`define CFG_LAST_BIT 7'h50

`define BIT_RESET_ENABLE 80
`define BIT_DYN_SEL_C 79
`define BIT_DYN_SEL_B 78
`define BIT_DYN_SEL_A 77
`define FLD_OSC_RANGE 76:74
`define BIT_STAT_SEL_C 73
`define BIT_STAT_SEL_B 72
`define BIT_STAT_SEL_A 71
`define FLD_OUT_C_DELAY 70:66
`define FLD_OUT_B_DELAY 65:61
`define FLD_GLB_C_DELAY 60:56
`define FLD_GLB_B_DELAY 55:51
`define FLD_GLB_A_DELAY 50:46
`define BIT_EXTRA_DELAY 45
`define FLD_FB_DELAY 44:40
`define FLD_FB_SOURCE 39:38
`define FLD_OUT_C_ROUTE 37:35
`define FLD_OUT_B_ROUTE 34:32
`define FLD_OUT_A_ROUTE 31:29
`define FLD_OUT_C_DIV 28:24
`define FLD_OUT_B_DIV 23:19
`define FLD_OUT_A_DIV 18:14
`define FLD_FB_DIV 13:7
`define FLD_IN_DIV 6:0

// Word addresses (byte address bits 5:2)
`define ADDR_W 4
`define REG_STAGE0 4'h0
`define REG_STAGE1 4'h1
`define REG_STAGE2 4'h2
`define REG_CONTROL 4'h3
`define REG_STATUS 4'h4
`define REG_ACTIVE0 4'h5
`define REG_ACTIVE1 4'h6
`define REG_ACTIVE2 4'h7

`define CTRL_DYNAMIC 0
`define CTRL_LOAD 1
`define CTRL_SHIFT_STAGE 2
`define STAGE2_BITS 16:0

`endif

// ===== rtl/clock_conditioner_pkg.sv
/*
  Types for the clock conditioner dynamic configuration block.
  Assumes clock_conditioner_cfg.svh sits beside it.
*/
`default_nettype none
`include "clock_conditioner_cfg.svh"
package clock_conditioner_pkg;
  typedef logic [`CFG_WIDTH-1:0] cfg_word_t;

  typedef struct packed {
    logic reset_enable;
    logic dynamic_select_c;
    logic dynamic_select_b;
    logic dynamic_select_a;
    logic [2:0] oscillator_range_select;
    logic static_select_c;
    logic static_select_b;
    logic static_select_a;
    logic [4:0] output_c_delay;
    logic [4:0] output_b_delay;
    logic [4:0] global_c_delay;
    logic [4:0] global_b_delay;
    logic [4:0] global_a_delay;
    logic extra_delay_select;
    logic [4:0] feedback_delay;
    logic [1:0] feedback_source_select;
    logic [2:0] output_c_route_select;
    logic [2:0] output_b_route_select;
    logic [2:0] output_a_route_select;
    logic [4:0] output_c_divider;
    logic [4:0] output_b_divider;
    logic [4:0] output_a_divider;
    logic [6:0] feedback_divider;
    logic [6:0] input_divider;
  } clock_conditioner_cfg_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [`ADDR_W-1:0] adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef enum logic [1:0] {SHIFT_IDLE, SHIFT_RUN, SHIFT_DONE} shift_state_e;
endpackage
`default_nettype wire

// ===== rtl/cfg_shift_register.sv
/*
  81-bit serial configuration shift register with a parallel holding
  stage. Bit 0 enters first, so after 81 shifts bit 0 holds the first.
  Assumes control from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clock_conditioner_cfg.svh"
module cfg_shift_register (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic shift_in,
  input wire logic data_in,
  input wire logic load_in,
  input wire logic [`CFG_WIDTH-1:0] static_in,
  input wire logic use_dynamic_in,
  output logic [`CFG_WIDTH-1:0] shift_out,
  output logic [`CFG_WIDTH-1:0] config_out
);
  logic [`CFG_WIDTH-1:0] shift_q, shift_d, hold_q, hold_d;

  always_comb begin
    shift_d = shift_q;
    hold_d = hold_q;
    if (shift_in) begin
      shift_d = {data_in, shift_q[`CFG_WIDTH-1:1]};
    end
    if (load_in) begin
      hold_d = shift_q;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      shift_q <= '0;
      hold_q <= '0;
    end else if (enable_in) begin
      shift_q <= shift_d;
      hold_q <= hold_d;
    end
  end

  assign shift_out = shift_q;
  assign config_out = use_dynamic_in ? hold_q : static_in;
endmodule
`default_nettype wire

// ===== rtl/clock_conditioner_dynamic_config.sv
/*
  Dynamic configuration path of a clock conditioner: Wishbone staging of
  an 81-bit word, serial shift into the configuration register, load, and
  fanout of the decoded fields. Also a serial port fed from an internal
  JTAG tile through fabric logic.
  Assumes a classic Wishbone master on clock_in; serial pins are
  asynchronous and synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "clock_conditioner_cfg.svh"
module clock_conditioner_dynamic_config (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [5:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic jtag_shift_in,
  input wire logic jtag_data_in,
  input wire logic jtag_load_in,
  output logic jtag_data_out,
  input wire logic [`CFG_WIDTH-1:0] static_config_in,
  output clock_conditioner_pkg::clock_conditioner_cfg_s config_out
);
  clock_conditioner_pkg::wb_req_s req;
  clock_conditioner_pkg::shift_state_e state_q, state_d;
  logic [`CFG_WIDTH-1:0] stage_q, stage_d, shreg, active;
  logic [`CFG_CNT_W-1:0] count_q, count_d;
  logic dynamic_q, dynamic_d, busy_q, busy_d, done_q, done_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] sync1_q, sync2_q, sync3_q;
  logic j_shift, j_data, j_load_rise, jdo_q;
  logic do_shift, do_data, do_load;

  // Byte lane merge, used for the three stage words
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in, sel: wb_sel_in,
                 adr: wb_adr_in[5:2], dat: wb_dat_in};

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (enable_in) begin
      sync1_q <= {jtag_load_in, jtag_data_in, jtag_shift_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  // Shift strobe is an edge so one tile clock moves one bit
  assign j_shift = sync2_q[0] & ~sync3_q[0];
  assign j_data = sync2_q[1];
  assign j_load_rise = sync2_q[2] & ~sync3_q[2];

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    stage_d = stage_q;
    dynamic_d = dynamic_q;
    busy_d = busy_q;
    done_d = done_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    do_shift = 1'b0;
    do_data = 1'b0;
    do_load = 1'b0;
    if (req.cyc && req.stb && !ack_q) begin
      ack_d = 1'b1;
      if (req.we) begin
        unique case (req.adr)
          `REG_STAGE0: stage_d[31:0] = merge(stage_q[31:0], req.dat, req.sel);
          `REG_STAGE1: stage_d[63:32] = merge(stage_q[63:32], req.dat, req.sel);
          `REG_STAGE2: stage_d[80:64] = 17'(merge({15'h0000, stage_q[80:64]}, req.dat, req.sel));
          `REG_CONTROL: begin
            if (req.sel[0]) begin
              dynamic_d = req.dat[`CTRL_DYNAMIC];
              if (req.dat[`CTRL_SHIFT_STAGE] && state_q == clock_conditioner_pkg::SHIFT_IDLE) begin
                state_d = clock_conditioner_pkg::SHIFT_RUN;
                count_d = '0;
                busy_d = 1'b1;
              end
              // Load ignored mid-shift to avoid partial word
              if (req.dat[`CTRL_LOAD] && state_q != clock_conditioner_pkg::SHIFT_RUN) begin
                do_load = 1'b1;
              end
            end
          end
          default: ;
        endcase
      end else begin
        unique case (req.adr)
          `REG_STAGE0: rdata_d = stage_q[31:0];
          `REG_STAGE1: rdata_d = stage_q[63:32];
          `REG_STAGE2: rdata_d = {15'h0000, stage_q[80:64]};
          `REG_CONTROL: rdata_d = {29'h00000000, 1'b0, 1'b0, dynamic_q};
          // Bit 8 tells software a finished shift still awaits its load
          `REG_STATUS: rdata_d = {23'h000000, done_q, count_q, busy_q};
          `REG_ACTIVE0: rdata_d = active[31:0];
          `REG_ACTIVE1: rdata_d = active[63:32];
          `REG_ACTIVE2: rdata_d = {15'h0000, active[80:64]};
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
    unique case (state_q)
      clock_conditioner_pkg::SHIFT_IDLE: begin
        do_shift = j_shift;
        do_data = j_data;
        if (j_load_rise) begin
          do_load = 1'b1;
        end
      end
      clock_conditioner_pkg::SHIFT_RUN: begin
        do_shift = 1'b1;
        do_data = stage_q[count_q];
        count_d = count_q + 7'h01;
        if (count_q == `CFG_LAST_BIT) begin
          state_d = clock_conditioner_pkg::SHIFT_DONE;
        end
      end
      clock_conditioner_pkg::SHIFT_DONE: begin
        busy_d = 1'b0;
        done_d = 1'b1;
        state_d = clock_conditioner_pkg::SHIFT_IDLE;
      end
      default: state_d = clock_conditioner_pkg::SHIFT_IDLE;
    endcase
    // Completion wins over a load in the same cycle
    if (do_load && state_q != clock_conditioner_pkg::SHIFT_DONE) begin
      done_d = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= clock_conditioner_pkg::SHIFT_IDLE;
      count_q <= '0;
      stage_q <= '0;
      dynamic_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= '0;
      jdo_q <= 1'b0;
    end else if (enable_in) begin
      state_q <= state_d;
      count_q <= count_d;
      stage_q <= stage_d;
      dynamic_q <= dynamic_d;
      busy_q <= busy_d;
      done_q <= done_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      jdo_q <= shreg[0];
    end
  end

  cfg_shift_register shifter (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(enable_in),
    .shift_in(do_shift),
    .data_in(do_data),
    .load_in(do_load),
    .static_in(static_config_in),
    .use_dynamic_in(dynamic_q),
    .shift_out(shreg),
    .config_out(active)
  );

  always_comb begin
    config_out.reset_enable = active[`BIT_RESET_ENABLE];
    config_out.dynamic_select_c = active[`BIT_DYN_SEL_C];
    config_out.dynamic_select_b = active[`BIT_DYN_SEL_B];
    config_out.dynamic_select_a = active[`BIT_DYN_SEL_A];
    config_out.oscillator_range_select = active[`FLD_OSC_RANGE];
    config_out.static_select_c = active[`BIT_STAT_SEL_C];
    config_out.static_select_b = active[`BIT_STAT_SEL_B];
    config_out.static_select_a = active[`BIT_STAT_SEL_A];
    config_out.output_c_delay = active[`FLD_OUT_C_DELAY];
    config_out.output_b_delay = active[`FLD_OUT_B_DELAY];
    config_out.global_c_delay = active[`FLD_GLB_C_DELAY];
    config_out.global_b_delay = active[`FLD_GLB_B_DELAY];
    config_out.global_a_delay = active[`FLD_GLB_A_DELAY];
    config_out.extra_delay_select = active[`BIT_EXTRA_DELAY];
    config_out.feedback_delay = active[`FLD_FB_DELAY];
    config_out.feedback_source_select = active[`FLD_FB_SOURCE];
    config_out.output_c_route_select = active[`FLD_OUT_C_ROUTE];
    config_out.output_b_route_select = active[`FLD_OUT_B_ROUTE];
    config_out.output_a_route_select = active[`FLD_OUT_A_ROUTE];
    config_out.output_c_divider = active[`FLD_OUT_C_DIV];
    config_out.output_b_divider = active[`FLD_OUT_B_DIV];
    config_out.output_a_divider = active[`FLD_OUT_A_DIV];
    config_out.feedback_divider = active[`FLD_FB_DIV];
    config_out.input_divider = active[`FLD_IN_DIV];
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdata_q;
  assign jtag_data_out = jdo_q;
endmodule
`default_nettype wire

// ===== dv/cfg_checker_sva.sv
/* Port checker for the clock conditioner config block.
   Assumes binding onto the top module; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
`include "clock_conditioner_cfg.svh"
module cfg_checker_sva (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic enable_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [5:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic jtag_data_out,
  input wire logic [`CFG_WIDTH-1:0] static_config_in,
  input wire clock_conditioner_pkg::clock_conditioner_cfg_s config_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out && enable_in;
  a_ack_pulse: assert property (wb_ack_out && enable_in |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_ack_latency: assert property (req |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(req))
    else $error("ack without request");
  a_read_held: assert property (!wb_ack_out |=> $stable(wb_dat_out) || wb_ack_out)
    else $error("read data changed without ack");
  a_unmapped_zero: assert property (req && !wb_we_in && wb_adr_in[5:2] > 4'h7 |=> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  a_static_reset: assert property ($fell(reset_in) |-> config_out == static_config_in)
    else $error("config not static after reset");
  a_enable_hold: assert property (!enable_in |=> $stable(wb_ack_out) && $stable(wb_dat_out) && $stable(jtag_data_out))
    else $error("state moved while disabled");
  a_reset_clear: assert property (disable iff (1'b0) reset_in && enable_in |=> !wb_ack_out && wb_dat_out == 32'h0)
    else $error("outputs not cleared by reset");
endmodule
bind clock_conditioner_dynamic_config cfg_checker_sva cfg_checker_sva_inst (.clock_in(clock_in),
  .reset_in(reset_in), .enable_in(enable_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .jtag_data_out(jtag_data_out), .static_config_in(static_config_in), .config_out(config_out));
`default_nettype wire

// ===== dv/tile_controller_model.sv
/* Behavioural fabric controller feeding the tile serial port.
   Assumes the block's clock; driven by task calls from the bench. */
`timescale 1ns/1ns
`default_nettype none
module tile_controller_model (
  input wire logic clock_in,
  output logic shift_out,
  output logic data_out,
  output logic load_out
);
  initial begin
    shift_out = 1'b0;
    data_out = 1'b0;
    load_out = 1'b0;
  end
  task automatic send_word(input logic [80:0] w, input int gap);
    for (int i = 0; i < 81; i++) begin
      @(posedge clock_in);
      data_out <= w[i];
      repeat (gap) @(posedge clock_in);
      shift_out <= 1'b1;
      repeat (gap + 1) @(posedge clock_in);
      shift_out <= 1'b0;
      repeat (gap) @(posedge clock_in);
      // Hold time over: show a changed level
      data_out <= ~w[i];
    end
    load_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    load_out <= 1'b0;
    repeat (6) @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

// ===== dv/clock_conditioner_dynamic_config_tb_top.sv
/* Self-checking bench: bus and tile paths into the config register.
   Assumes the design files and the tile controller model. */
`timescale 1ns/1ns
`default_nettype none
module clock_conditioner_dynamic_config_tb_top;
  logic clock_in, reset_in, enable_in, cyc, stb, we, wb_ack_out, jtag_data_out, t_shift, t_data, t_load;
  logic [5:0] adr;
  logic [31:0] wdat, rdat, wb_dat_out;
  clock_conditioner_pkg::clock_conditioner_cfg_s config_out;
  int error_cnt, n_compared, n;
  localparam logic [80:0] static_cfg = 81'h1_5555_AAAA_5555_AAAA_3C3C;
  localparam logic [80:0] pat = 81'h1_2345_6789_ABCD_EF01_2345;
  localparam logic [80:0] q = 81'h0_F0E1_D2C3_B4A5_9687_7869;
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  clock_conditioner_dynamic_config clock_conditioner_dynamic_config_inst (.clock_in(clock_in),
    .reset_in(reset_in), .enable_in(enable_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_sel_in(4'hF), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .jtag_shift_in(t_shift), .jtag_data_in(t_data), .jtag_load_in(t_load), .jtag_data_out(jtag_data_out),
    .static_config_in(static_cfg), .config_out(config_out));
  tile_controller_model tile_inst (.clock_in(clock_in), .shift_out(t_shift), .data_out(t_data),
    .load_out(t_load));
  task automatic chk(input logic [80:0] got, input logic [80:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Look at ack mid-cycle, where it has settled before the next edge
    do begin
      @(negedge clock_in);
      k++;
    end while (wb_ack_out !== 1'b1 && k < 20);
    rdat = wb_dat_out;
    if (k >= 20) error_cnt++;
    @(posedge clock_in);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk({49'h0, rdat}, {49'h0, exp});
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clock_in);
    error_cnt++;
    conclude();
  end
  initial begin
    {reset_in, enable_in, cyc, stb, we, adr, wdat} = {2'h3, 3'h0, 6'h00, 32'h0};
    error_cnt = 0;
    n_compared = 0;
    repeat (12) @(posedge clock_in);
    reset_in <= 1'b0;
    @(posedge clock_in);
    chk(config_out, static_cfg);
    chk({80'h0, jtag_data_out}, 81'h0);
    rd_chk(6'h10, 32'h0);
    enable_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    enable_in <= 1'b1;
    xfer(1'b1, 6'h00, pat[31:0]);
    xfer(1'b1, 6'h04, pat[63:32]);
    xfer(1'b1, 6'h08, {15'h0, pat[80:64]});
    rd_chk(6'h04, pat[63:32]);
    xfer(1'b1, 6'h0C, 32'h4);
    n = 0;
    do begin
      xfer(1'b0, 6'h10, 32'h0);
      n++;
    end while (rdat[0] !== 1'b0 && n < 200);
    if (n >= 200) error_cnt++;
    // Done set, all 81 bits counted, no longer busy
    rd_chk(6'h10, 32'h000001A2);
    xfer(1'b1, 6'h0C, 32'h3);
    @(posedge clock_in);
    chk(config_out, pat);
    rd_chk(6'h1C, {15'h0, pat[80:64]});
    rd_chk(6'h14, pat[31:0]);
    rd_chk(6'h3C, 32'h0);
    tile_inst.send_word(q, 3);
    chk(config_out, q);
    chk({80'h0, jtag_data_out}, {80'h0, q[0]});
    xfer(1'b1, 6'h0C, 32'h0);
    @(posedge clock_in);
    chk(config_out, static_cfg);
    conclude();
  end
endmodule
`default_nettype wire
